/* rtl/bus_cfg_pkg.sv */
`default_nettype none
package bus_cfg_pkg;
    // ========================================
    // Region widths
    localparam logic WIDTH_8  = 1'h0;
    localparam logic WIDTH_16 = 1'h1;
    // Strap level that selects a 16-bit boot
    localparam logic STRAP_WIDE = 1'h1;
    // Chip select lines: upper, lower, four mid, seven periph
    localparam int   NUM_SELECTS = 13;
    localparam int   SEL_UPPER   = 0;
    localparam int   SEL_LOWER   = 1;
    localparam int   SEL_MID3    = 5;
    localparam logic [NUM_SELECTS-1:0] SELECTS_IDLE = 13'h1fff;
    // Width field positions inside the auxiliary configuration word
    localparam int   AUX_BITS    = 4;
    localparam int   AUX_IO      = 0;
    localparam int   AUX_MID     = 1;
    localparam int   AUX_LOWER   = 2;
    localparam int   AUX_UPPER   = 3;
    // Reset value without the upper bit, which follows the strap
    localparam logic [AUX_BITS-1:0] AUX_RESET = 4'h7;
    // Address region of an access
    typedef enum logic [1:0] {
        REG_LOWER = 2'h0,
        REG_MID   = 2'h1,
        REG_UPPER = 2'h2,
        REG_IO    = 2'h3
    } region_t;
    // Bus ownership states, Gray coded along the usual path
    typedef enum logic [1:0] {
        OWN_BUS   = 2'h0,
        WAIT_IDLE = 2'h1,
        NEGATE    = 2'h3,
        RELEASED  = 2'h2
    } arb_state_t;
endpackage : bus_cfg_pkg
`default_nettype wire

/* rtl/width_if.sv */
`default_nettype none
interface width_if;
    import bus_cfg_pkg::*;
    logic [AUX_BITS-1:0] widths;
    bus_cfg_pkg::region_t region;
    logic                periph;
    logic                wide;
    modport cfg (output widths, region, periph, input wide);
    modport sel (input widths, region, periph, output wide);
endinterface : width_if
`default_nettype wire

/* rtl/access_width.sv */
`default_nettype none
module access_width (
    width_if.sel w
);
    import bus_cfg_pkg::*;
    // ========================================
    // Width lookup for one access
    // Periph selects in the I/O region fall back to the mid width, other
    // I/O accesses use the I/O width; each memory region uses its own width.
    always_comb begin
        case (w.region)
            REG_LOWER: w.wide = w.widths[AUX_LOWER];
            REG_UPPER: w.wide = w.widths[AUX_UPPER];
            REG_IO:    w.wide = w.periph ? w.widths[AUX_MID]
                                         : w.widths[AUX_IO];
            default:   w.wide = w.widths[AUX_MID];
        endcase
    end
endmodule : access_width
`default_nettype wire

/* rtl/boot_width_and_bus_release.sv */
`default_nettype none
module boot_width_and_bus_release (
    input  wire logic                              clock,
    input  wire logic                              rst,
    input  wire logic                              boot_width_strap,
    input  wire logic                              aux_write,
    input  wire logic [bus_cfg_pkg::AUX_BITS-1:0]  aux_wdata,
    output logic      [bus_cfg_pkg::AUX_BITS-1:0]  aux_config_reg,
    output logic                                   boot_wide,
    input  wire logic                              hold_req,
    input  wire logic                              cycle_busy,
    output logic                                   bus_hold_ack,
    input  wire logic [bus_cfg_pkg::NUM_SELECTS-1:0] select_n_core,
    input  wire logic [bus_cfg_pkg::NUM_SELECTS-1:0] prog_io_pin,
    output logic      [bus_cfg_pkg::NUM_SELECTS-1:0] select_n_out,
    output logic      [bus_cfg_pkg::NUM_SELECTS-1:0] select_oe,
    output logic      [bus_cfg_pkg::NUM_SELECTS-1:0] select_pullup_en,
    input  wire bus_cfg_pkg::region_t              access_region,
    input  wire logic                              access_periph,
    output logic                                   access_wide
);
    import bus_cfg_pkg::*;

    // ========================================
    // State
    typedef struct packed {
        logic                   strap_meta;
        logic                   strap_sync;
        logic                   in_reset;
        logic                   boot_wide;
        logic [AUX_BITS-1:0]    aux;
        logic                   hold_meta;
        logic                   hold_sync;
        arb_state_t             arb;
        logic [NUM_SELECTS-1:0] sel_n;
        logic [NUM_SELECTS-1:0] oe;
    } state_t;

    state_t state_reg;
    state_t state_next;

    width_if wif ();

    // ========================================
    // Next state
    always_comb begin
        state_next = state_reg;
        // Pin inputs cross into the core clock through two flops
        state_next.strap_meta = boot_width_strap;
        state_next.strap_sync = state_reg.strap_meta;
        state_next.hold_meta  = hold_req;
        state_next.hold_sync  = state_reg.hold_meta;
        state_next.in_reset   = 1'h0;
        // Capture on the first edge after reset lets go; held afterwards
        if (state_reg.in_reset) begin
            state_next.boot_wide = state_reg.strap_sync;
            state_next.aux[AUX_UPPER] = state_reg.strap_sync;
        end else if (aux_write) begin
            state_next.aux[AUX_IO]    = aux_wdata[AUX_IO];
            state_next.aux[AUX_MID]   = aux_wdata[AUX_MID];
            state_next.aux[AUX_LOWER] = aux_wdata[AUX_LOWER];
            // A 16-bit boot keeps the upper region wide
            if (state_reg.boot_wide != STRAP_WIDE) begin
                state_next.aux[AUX_UPPER] = aux_wdata[AUX_UPPER];
            end
        end
        // Arbitration
        case (state_reg.arb)
            OWN_BUS: begin
                state_next.sel_n = select_n_core;
                state_next.oe    = '1;
                if (state_reg.hold_sync) begin
                    state_next.arb = WAIT_IDLE;
                end
            end
            WAIT_IDLE: begin
                state_next.sel_n = select_n_core;
                if (!state_reg.hold_sync) begin
                    state_next.arb = OWN_BUS;
                end else if (!cycle_busy) begin
                    state_next.arb   = NEGATE;
                    state_next.sel_n = SELECTS_IDLE;
                end
            end
            NEGATE: begin
                // One cycle of active high drive before letting go
                state_next.oe  = '0;
                state_next.arb = RELEASED;
            end
            default: begin
                if (!state_reg.hold_sync) begin
                    state_next.arb   = OWN_BUS;
                    state_next.sel_n = SELECTS_IDLE;
                    state_next.oe    = '1;
                end
            end
        endcase
    end

    // ========================================
    // Registers
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg            <= '0;
            // Strap synchroniser keeps running so it is full at release
            state_reg.strap_meta <= state_next.strap_meta;
            state_reg.strap_sync <= state_next.strap_sync;
            state_reg.in_reset   <= 1'h1;
            state_reg.boot_wide  <= STRAP_WIDE;
            state_reg.aux        <= AUX_RESET;
            state_reg.aux[AUX_UPPER] <= WIDTH_16;
            state_reg.arb        <= OWN_BUS;
            state_reg.sel_n      <= SELECTS_IDLE;
            state_reg.oe         <= '1;
        end else begin
            state_reg <= state_next;
        end
    end

    // ========================================
    // Outputs
    // No refresh or alternate lower timing exists, so selects pass as is
    assign select_n_out   = state_reg.sel_n;
    assign select_oe      = state_reg.oe;
    assign aux_config_reg = state_reg.aux;
    assign boot_wide      = state_reg.boot_wide;
    assign bus_hold_ack   = (state_reg.arb == NEGATE) ||
                            (state_reg.arb == RELEASED);

    // Pull-up is on whenever released, whatever the pin's I/O role
    always_comb begin
        for (int i = 0; i < NUM_SELECTS; i++) begin
            select_pullup_en[i] = !state_reg.oe[i] ||
                                  (prog_io_pin[i] && bus_hold_ack);
        end
    end

    // Width of the current access
    assign wif.widths = state_reg.aux;
    assign wif.region = access_region;
    assign wif.periph = access_periph;
    assign access_wide = wif.wide;

    access_width u_width (
        .w (wif.sel)
    );

    // ========================================
    // Checks
    property p_grant_negates;
        @(posedge clock) disable iff (rst)
        $rose(bus_hold_ack) |-> select_oe == '1 && select_n_out == '1
            ##1 select_oe == '0;
    endproperty
    a_grant_negates: assert property (p_grant_negates)
        else $error("selects not negated before release");

    property p_released_pullup;
        @(posedge clock) disable iff (rst)
        select_oe == '0 |-> select_pullup_en == '1;
    endproperty
    a_released_pullup: assert property (p_released_pullup)
        else $error("pull-up off while released");

    property p_busy_blocks;
        @(posedge clock) disable iff (rst)
        state_reg.arb == WAIT_IDLE && cycle_busy |=> !bus_hold_ack;
    endproperty
    a_busy_blocks: assert property (p_busy_blocks)
        else $error("hold granted during busy cycle");

    property p_resume;
        @(posedge clock) disable iff (rst)
        state_reg.arb == RELEASED && !state_reg.hold_sync
            |=> !bus_hold_ack && select_oe == '1;
    endproperty
    a_resume: assert property (p_resume)
        else $error("drive not resumed after hold drop");

    property p_strap_capture;
        @(posedge clock)
        $fell(rst) |=> boot_wide == $past(state_reg.strap_sync);
    endproperty
    a_strap_capture: assert property (p_strap_capture)
        else $error("strap not captured at reset release");

    property p_strap_hold;
        @(posedge clock) disable iff (rst)
        !state_reg.in_reset |=> $stable(boot_wide);
    endproperty
    a_strap_hold: assert property (p_strap_hold)
        else $error("boot width changed outside reset");

    property p_wide_upper_locked;
        @(posedge clock) disable iff (rst)
        boot_wide && !state_reg.in_reset
            |=> aux_config_reg[AUX_UPPER] == WIDTH_16;
    endproperty
    a_wide_upper_locked: assert property (p_wide_upper_locked)
        else $error("upper width not 16 bits after wide boot");

    property p_narrow_write;
        @(posedge clock) disable iff (rst)
        !boot_wide && !state_reg.in_reset && aux_write
            |=> aux_config_reg == $past(aux_wdata);
    endproperty
    a_narrow_write: assert property (p_narrow_write)
        else $error("width write not taken");

    property p_lower_width;
        @(posedge clock) disable iff (rst)
        access_region == REG_LOWER
            |-> access_wide == aux_config_reg[AUX_LOWER];
    endproperty
    a_lower_width: assert property (p_lower_width)
        else $error("lower region width mismatch");
endmodule : boot_width_and_bus_release
`default_nettype wire

/* test/select_far_side.sv */
`default_nettype none
// ========================================
// Far side: memory chip selects plus an external bus master
module select_far_side (
    input  wire logic                                clock,
    input  wire logic                                bus_hold_ack,
    input  wire logic [bus_cfg_pkg::NUM_SELECTS-1:0] select_n_out,
    input  wire logic [bus_cfg_pkg::NUM_SELECTS-1:0] select_oe,
    input  wire logic [bus_cfg_pkg::NUM_SELECTS-1:0] select_pullup_en,
    input  wire logic [bus_cfg_pkg::NUM_SELECTS-1:0] pull_low,
    output logic      [bus_cfg_pkg::NUM_SELECTS-1:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [bus_cfg_pkg::NUM_SELECTS-1:0] last_reg;
    // Undriven line with no pull-up flips, so a stale value never passes
    always_comb begin
        for (int k = 0; k < bus_cfg_pkg::NUM_SELECTS; k++) begin
            if (select_oe[k])
                pin_level[k] = select_n_out[k];
            else if (bus_hold_ack && pull_low[k])
                pin_level[k] = 1'h0;
            else
                pin_level[k] = select_pullup_en[k] ? 1'h1 : ~last_reg[k];
        end
    end
    always_ff @(posedge clock) last_reg <= pin_level;
endmodule // select_far_side
`default_nettype wire

/* test/tb_boot_width_and_bus_release.sv */
`default_nettype none
module tb_boot_width_and_bus_release;
    timeunit 1ns;
    timeprecision 1ps;
    import bus_cfg_pkg::*;
    // ========================================
    // Stimulus and observed signals
    logic clock = 1'h0, rst = 1'h1, boot_width_strap = 1'h0;
    logic aux_write = 1'h0, hold_req = 1'h0, cycle_busy = 1'h0;
    logic access_periph = 1'h0, boot_wide, bus_hold_ack, access_wide;
    logic [AUX_BITS-1:0] aux_wdata = 4'h0, aux_config_reg;
    logic [NUM_SELECTS-1:0] select_n_core = SELECTS_IDLE;
    logic [NUM_SELECTS-1:0] prog_io_pin = 13'h0, pull_low = 13'h0;
    logic [NUM_SELECTS-1:0] select_n_out, select_oe, select_pullup_en;
    logic [NUM_SELECTS-1:0] pin_level;
    region_t access_region = REG_LOWER;
    int bad_count = 0, num_checks = 0, cycles = 0, i;
    always #10 clock = ~clock;
    boot_width_and_bus_release dut (.clock(clock), .rst(rst),
        .boot_width_strap(boot_width_strap), .aux_write(aux_write),
        .aux_wdata(aux_wdata), .aux_config_reg(aux_config_reg),
        .boot_wide(boot_wide), .hold_req(hold_req),
        .cycle_busy(cycle_busy), .bus_hold_ack(bus_hold_ack),
        .select_n_core(select_n_core), .prog_io_pin(prog_io_pin),
        .select_n_out(select_n_out), .select_oe(select_oe),
        .select_pullup_en(select_pullup_en),
        .access_region(access_region), .access_periph(access_periph),
        .access_wide(access_wide));
    select_far_side far (.clock(clock), .bus_hold_ack(bus_hold_ack),
        .select_n_out(select_n_out), .select_oe(select_oe),
        .select_pullup_en(select_pullup_en), .pull_low(pull_low),
        .pin_level(pin_level));
    // ========================================
    // Shared tasks
    task automatic chk(string what, logic [12:0] seen, logic [12:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Strap is set well before release so the synchroniser is full
    task automatic do_reset(logic strap);
        @(posedge clock);
        boot_width_strap <= strap;
        rst <= 1'h1;
        repeat (20) @(posedge clock);
        rst <= 1'h0;
        repeat (3) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic write_aux(logic [3:0] d);
        @(posedge clock);
        aux_write <= 1'h1;
        aux_wdata <= d;
        @(posedge clock);
        aux_write <= 1'h0;
        @(negedge clock);
    endtask
    task automatic wait_ack(logic v);
        // Look only at settled values, never in the launching time step
        @(negedge clock);
        for (i = 0; i < 20 && bus_hold_ack !== v; i++) @(negedge clock);
        chk("bus_hold_ack", 13'(bus_hold_ack), 13'(v));
    endtask
    function automatic logic exp_wide(int k, logic [3:0] a);
        case (k[1:0])
            2'h0: return a[AUX_LOWER];
            2'h1: return a[AUX_MID];
            2'h2: return a[AUX_UPPER];
            default: return k[2] ? a[AUX_MID] : a[AUX_IO];
        endcase
    endfunction
    // Hang guard, far above the hundred or so cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            end_of_test();
        end
    end
    // ========================================
    // Test sequence
    initial begin
        do_reset(1'h0);
        chk("boot_wide", 13'(boot_wide), 13'h0);
        chk("aux", 13'(aux_config_reg), 13'h7);
        @(posedge clock);
        boot_width_strap <= 1'h1;
        repeat (5) @(posedge clock);
        @(negedge clock);
        chk("boot_wide", 13'(boot_wide), 13'h0);
        write_aux(4'ha);
        chk("aux", 13'(aux_config_reg), 13'ha);
        for (int k = 0; k < 8; k++) begin
            @(posedge clock);
            access_region <= region_t'(k[1:0]);
            access_periph <= k[2];
            @(negedge clock);
            chk("width", 13'(access_wide), 13'(exp_wide(k, 4'ha)));
        end
        $display("width test done");
        @(posedge clock);
        select_n_core <= 13'h0fde;
        prog_io_pin <= 13'h1ff0;
        cycle_busy <= 1'h1;
        repeat (2) @(posedge clock);
        @(negedge clock);
        chk("select_n_out", select_n_out, 13'h0fde);
        @(posedge clock);
        hold_req <= 1'h1;
        repeat (10) @(posedge clock);
        @(negedge clock);
        chk("bus_hold_ack", 13'(bus_hold_ack), 13'h0);
        @(posedge clock);
        cycle_busy <= 1'h0;
        wait_ack(1'h1);
        chk("select_n_out", select_n_out, SELECTS_IDLE);
        chk("select_oe", select_oe, 13'h1fff);
        chk("select_pullup_en", select_pullup_en, 13'h1ff0);
        @(negedge clock);
        chk("select_oe", select_oe, 13'h0);
        chk("select_pullup_en", select_pullup_en, 13'h1fff);
        @(posedge clock);
        pull_low <= 13'h0001;
        @(negedge clock);
        chk("pin_level", pin_level, 13'h1ffe);
        @(posedge clock);
        pull_low <= 13'h0;
        hold_req <= 1'h0;
        wait_ack(1'h0);
        chk("select_oe", select_oe, 13'h1fff);
        // Hold withdrawn during a busy cycle must not be granted later
        @(posedge clock);
        cycle_busy <= 1'h1;
        hold_req <= 1'h1;
        repeat (6) @(posedge clock);
        hold_req <= 1'h0;
        repeat (4) @(posedge clock);
        cycle_busy <= 1'h0;
        repeat (2) @(posedge clock);
        @(negedge clock);
        chk("bus_hold_ack", 13'(bus_hold_ack), 13'h0);
        $display("hold test done");
        do_reset(1'h1);
        chk("boot_wide", 13'(boot_wide), 13'h1);
        chk("aux", 13'(aux_config_reg), 13'hf);
        write_aux(4'h0);
        chk("aux", 13'(aux_config_reg), 13'h8);
        $display("boot test done");
        end_of_test();
    end
endmodule // tb_boot_width_and_bus_release
`default_nettype wire
